//--- logic/brc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef BRC_REGS_SVH
`define BRC_REGS_SVH

// ==========================================================
// Register map (byte addresses on the bus)
`define BRC_ADDR_W        4
`define BRC_CTRL_OFS      4'h0
`define BRC_SWEN_BIT      7
`define BRC_READY_BIT     0
`define BRC_RSVD_HI       6
`define BRC_RSVD_LO       1
`define BRC_SWEN_RST      1'b1

// ==========================================================
// Mode codes of the two-bit configuration field
`define BRC_MODE_OFF      2'h0
`define BRC_MODE_SW       2'h1
`define BRC_MODE_NOSLEEP  2'h2
`define BRC_MODE_ON       2'h3

// ==========================================================
// Timing: figures in ns, counts derived from the clock period
`define BRC_CLK_NS        50
`define BRC_GLITCH_NS     1000
`define BRC_SETTLE_NS     2000
`define BRC_CNT_W         6
// Least times, rounded up to whole cycles
`define BRC_GLITCH_CYC    ((`BRC_GLITCH_NS + `BRC_CLK_NS - 1) / `BRC_CLK_NS)
`define BRC_SETTLE_CYC    ((`BRC_SETTLE_NS + `BRC_CLK_NS - 1) / `BRC_CLK_NS)

`endif

//--- logic/brc_pkg.sv
// Types shared by the brown-out reset control block
package brc_pkg;

  // ==========================================================
  // Execution gate states
  typedef enum logic [1:0] {
    BRC_ST_HOLD,
    BRC_ST_RUN,
    BRC_ST_SLEEP
  } brc_state_t;

endpackage

//--- logic/brc_glitch_filter.sv
// Supply noise filter: trips only on a low excursion longer than the glitch time
`timescale 1ns/1ps
`include "brc_regs.svh"

module brc_glitch_filter
  import brc_pkg::*;
(
  input  wire logic mclk,        // System clock
  input  wire logic sys_rst,     // Synchronous reset
  input  wire logic below_act,   // Supply low while detector enabled
  output logic      trip         // Low excursion outlasted the glitch time
);

  localparam logic [`BRC_CNT_W-1:0] LIM = `BRC_CNT_W'(`BRC_GLITCH_CYC);

  logic [`BRC_CNT_W-1:0] cnt_r;
  logic [`BRC_CNT_W-1:0] cnt_nxt;

  // Count consecutive low samples, saturate at the limit
  always_comb begin
    cnt_nxt = '0;
    if (below_act) begin
      cnt_nxt = (cnt_r == LIM) ? cnt_r : cnt_r + `BRC_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // One more low sample past the limit means longer than the glitch time
  assign trip = below_act && (cnt_r == LIM);

endmodule

//--- logic/brc_ready_timer.sv
// Detector settle timer: raises ready once the enabled detector has settled
`timescale 1ns/1ps
`include "brc_regs.svh"

module brc_ready_timer
  import brc_pkg::*;
(
  input  wire logic mclk,        // System clock
  input  wire logic sys_rst,     // Synchronous reset
  input  wire logic det_en,      // Detector enabled
  input  wire logic force_rdy,   // Detector forced on, counts as settled
  output logic      ready_r      // Detector active and settled
);

  localparam logic [`BRC_CNT_W-1:0] LIM = `BRC_CNT_W'(`BRC_SETTLE_CYC);

  logic [`BRC_CNT_W-1:0] cnt_r;
  logic [`BRC_CNT_W-1:0] cnt_nxt;
  logic                  ready_nxt;

  // Restart settling whenever the detector is switched off
  always_comb begin
    cnt_nxt   = '0;
    ready_nxt = 1'b0;
    if (det_en) begin
      cnt_nxt   = (cnt_r == LIM) ? cnt_r : cnt_r + `BRC_CNT_W'(1);
      ready_nxt = force_rdy || (cnt_r == LIM);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_r   <= '0;
      ready_r <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

endmodule

//--- logic/brc_brownout_reset_control.sv
// Brown-out reset control: mode decode, ready status, execution gate, register slave
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "brc_regs.svh"

module brc_brownout_reset_control
  import brc_pkg::*;
(
  input  wire logic                   mclk,                  // 20 MHz system clock
  input  wire logic                   sys_rst,               // Power-on reset, sync
  input  wire logic                   other_rst,             // Any other reset source
  input  wire logic [1:0]             brownout_mode_cfg,     // Mode configuration field
  input  wire logic                   brownout_level_select, // Trip level configuration
  input  wire logic                   sleep_state,           // Device is asleep
  input  wire logic                   supply_below,          // Comparator: supply low
  input  wire logic [`BRC_ADDR_W-1:0] avs_address,           // Byte address
  input  wire logic                   avs_read,              // Read request
  input  wire logic                   avs_write,             // Write request
  input  wire logic [31:0]            avs_writedata,         // Write data
  input  wire logic [3:0]             avs_byteenable,        // Byte lanes
  output logic [31:0]                 avs_readdata,          // Read data
  output logic                        avs_waitrequest,       // Stall request
  output logic                        detector_en_r,         // Enable to comparator
  output logic                        level_sel_r,           // Level to comparator
  output logic                        brownout_reset_r,      // Brown-out reset out
  output logic                        exec_enable_r          // Processor may execute
);

  // ==========================================================
  // Mode decode
  function automatic logic mode_enables(input logic [1:0] mode,
                                        input logic       sw_en,
                                        input logic       asleep);
    case (mode)
      `BRC_MODE_ON:      mode_enables = 1'b1;
      `BRC_MODE_NOSLEEP: mode_enables = !asleep;
      `BRC_MODE_SW:      mode_enables = sw_en;
      default:           mode_enables = 1'b0;
    endcase
  endfunction

  function automatic logic ctrl_hit(input logic [`BRC_ADDR_W-1:0] addr);
    ctrl_hit = (addr == `BRC_CTRL_OFS);
  endfunction

  logic sw_en_r;
  logic sw_en_nxt;
  logic det_en_nxt;
  logic level_sel_nxt;
  logic ready_r;
  logic trip;
  logic brownout_nxt;

  // ==========================================================
  // Register bus slave: one wait state, answer on the second cycle
  logic        wait_nxt;
  logic [31:0] rdata_nxt;
  logic        bus_req;
  logic        bus_take;
  logic        wr_ctrl;

  assign bus_req  = avs_read || avs_write;
  assign bus_take = bus_req && !avs_waitrequest;
  assign wr_ctrl  = bus_take && avs_write && ctrl_hit(avs_address) && avs_byteenable[0];

  // Prepare read data in the stall cycle; unmapped space reads zero
  always_comb begin
    wait_nxt  = !(bus_req && avs_waitrequest);
    rdata_nxt = avs_readdata;
    if (bus_req && avs_waitrequest) begin
      rdata_nxt = 32'h0000_0000;
      if (avs_read && ctrl_hit(avs_address)) begin
        rdata_nxt[`BRC_SWEN_BIT]  = sw_en_r;
        rdata_nxt[`BRC_READY_BIT] = ready_r;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= wait_nxt;
      avs_readdata    <= rdata_nxt;
    end
  end

  // ==========================================================
  // Software enable: brown-out reset wins over a write, other resets keep it
  always_comb begin
    sw_en_nxt = sw_en_r;
    if (brownout_reset_r) begin
      sw_en_nxt = `BRC_SWEN_RST;
    end else if (wr_ctrl) begin
      sw_en_nxt = avs_writedata[`BRC_SWEN_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sw_en_r <= `BRC_SWEN_RST;
    end else begin
      sw_en_r <= sw_en_nxt;
    end
  end

  // ==========================================================
  // Detector enable and trip level toward the comparator
  always_comb begin
    det_en_nxt    = mode_enables(brownout_mode_cfg, sw_en_r, sleep_state);
    level_sel_nxt = brownout_level_select;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      detector_en_r <= 1'b0;
      level_sel_r   <= 1'b0;
    end else begin
      detector_en_r <= det_en_nxt;
      level_sel_r   <= level_sel_nxt;
    end
  end

  // ==========================================================
  // Ready status and noise filter
  brc_ready_timer u_ready (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .det_en    (detector_en_r),
    .force_rdy (brownout_mode_cfg == `BRC_MODE_ON),
    .ready_r   (ready_r)
  );

  brc_glitch_filter u_filter (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .below_act (supply_below && detector_en_r),
    .trip      (trip)
  );

  // Hold reset while supply stays low; a disabled detector drops it
  always_comb begin
    brownout_nxt = detector_en_r && (trip || (brownout_reset_r && supply_below));
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      brownout_reset_r <= 1'b0;
    end else begin
      brownout_reset_r <= brownout_nxt;
    end
  end

  // ==========================================================
  // Execution gate
  brc_state_t state_r;
  brc_state_t state_nxt;
  logic       release_ok;
  logic       exec_nxt;

  // Gate on the enable the mode wants now: the registered one lags a wake by a cycle
  assign release_ok = !det_en_nxt || (ready_r && !supply_below);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BRC_ST_HOLD: begin
        if (!sleep_state && release_ok) begin
          state_nxt = BRC_ST_RUN;
        end
      end
      BRC_ST_RUN: begin
        if (sleep_state) begin
          state_nxt = BRC_ST_SLEEP;
        end
      end
      BRC_ST_SLEEP: begin
        // Mode 10 re-enables the detector on wake, so ready is low here
        if (!sleep_state) begin
          state_nxt = release_ok ? BRC_ST_RUN : BRC_ST_HOLD;
        end
      end
      default: state_nxt = BRC_ST_HOLD;
    endcase
    if (brownout_reset_r || other_rst) begin
      state_nxt = BRC_ST_HOLD;
    end
    exec_nxt = (state_nxt == BRC_ST_RUN);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r       <= BRC_ST_HOLD;
      exec_enable_r <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      exec_enable_r <= exec_nxt;
    end
  end

  // ==========================================================
  // Helper: run of consecutive low samples while enabled
  logic [`BRC_CNT_W-1:0] below_run_r;
  localparam logic [`BRC_CNT_W-1:0] GLITCH_LIM = `BRC_CNT_W'(`BRC_GLITCH_CYC);

  always_ff @(posedge mclk) begin
    if (sys_rst || !(supply_below && detector_en_r)) begin
      below_run_r <= '0;
    end else if (below_run_r != {`BRC_CNT_W{1'b1}}) begin
      below_run_r <= below_run_r + `BRC_CNT_W'(1);
    end
  end

  // ==========================================================
  // Assertions
  sequence s_read_done;
    avs_read && !avs_waitrequest && ctrl_hit(avs_address);
  endsequence

  sequence s_wake_clean;
    $fell(sleep_state) && !supply_below && !brownout_reset_r && !other_rst;
  endsequence

  property p_always_on;
    @(posedge mclk) disable iff (sys_rst)
      brownout_mode_cfg == `BRC_MODE_ON |=> detector_en_r;
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("detector off in always-on mode");

  property p_off_in_sleep;
    @(posedge mclk) disable iff (sys_rst)
      brownout_mode_cfg == `BRC_MODE_NOSLEEP |=> detector_en_r == !$past(sleep_state);
  endproperty
  a_off_in_sleep: assert property (p_off_in_sleep)
    else $error("detector enable wrong in off-in-sleep mode");

  property p_sw_mode;
    @(posedge mclk) disable iff (sys_rst)
      brownout_mode_cfg == `BRC_MODE_SW |=> detector_en_r == $past(sw_en_r);
  endproperty
  a_sw_mode: assert property (p_sw_mode)
    else $error("detector does not follow software enable");

  property p_sw_no_effect;
    @(posedge mclk) disable iff (sys_rst)
      brownout_mode_cfg != `BRC_MODE_SW && $stable(brownout_mode_cfg) &&
      $stable(sleep_state) && $changed(sw_en_r) |=> $stable(detector_en_r);
  endproperty
  a_sw_no_effect: assert property (p_sw_no_effect)
    else $error("software enable affected detector outside mode 01");

  property p_ready_read;
    @(posedge mclk) disable iff (sys_rst)
      s_read_done |-> avs_readdata[`BRC_READY_BIT] == $past(ready_r) &&
                      avs_readdata[`BRC_SWEN_BIT] == $past(sw_en_r);
  endproperty
  a_ready_read: assert property (p_ready_read)
    else $error("control read does not show ready or enable");

  property p_rsvd_zero;
    @(posedge mclk) disable iff (sys_rst)
      s_read_done |-> avs_readdata[`BRC_RSVD_HI:`BRC_RSVD_LO] == 6'h00 &&
                      avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved control bits read nonzero");

  property p_glitch_reject;
    @(posedge mclk) disable iff (sys_rst)
      $rose(brownout_reset_r) |-> $past(below_run_r) >= GLITCH_LIM;
  endproperty
  a_glitch_reject: assert property (p_glitch_reject)
    else $error("brown-out reset on a short excursion");

  property p_hold_reset;
    @(posedge mclk) disable iff (sys_rst)
      brownout_reset_r && supply_below && detector_en_r |=> brownout_reset_r ##0 !exec_enable_r;
  endproperty
  a_hold_reset: assert property (p_hold_reset)
    else $error("brown-out reset released while supply low");

  property p_swen_reset;
    @(posedge mclk) disable iff (sys_rst)
      $fell(sys_rst) |-> sw_en_r;
  endproperty
  a_swen_reset: assert property (p_swen_reset)
    else $error("software enable not set after reset");

  property p_exec_waits;
    @(posedge mclk) disable iff (sys_rst)
      $rose(exec_enable_r) && $past(det_en_nxt) |-> $past(ready_r) && !$past(supply_below);
  endproperty
  a_exec_waits: assert property (p_exec_waits)
    else $error("execution released before detector ready");

  property p_on_no_wake_delay;
    @(posedge mclk) disable iff (sys_rst)
      brownout_mode_cfg == `BRC_MODE_ON && $stable(brownout_mode_cfg) && ready_r &&
      state_r == BRC_ST_SLEEP ##0 s_wake_clean |=> exec_enable_r;
  endproperty
  a_on_no_wake_delay: assert property (p_on_no_wake_delay)
    else $error("wake-up delayed in always-on mode");

  property p_off_immediate;
    @(posedge mclk) disable iff (sys_rst)
      brownout_mode_cfg == `BRC_MODE_OFF && $past(brownout_mode_cfg) == `BRC_MODE_OFF &&
      !sleep_state && !other_rst && !brownout_reset_r |=> exec_enable_r;
  endproperty
  a_off_immediate: assert property (p_off_immediate)
    else $error("execution not immediate with detector off");

endmodule

//--- tb/test_brc_brownout_reset_control.sv
// Self-checking bench for the brown-out reset control block
`timescale 1ns/1ps
`include "brc_regs.svh"

module test_brc_brownout_reset_control;
  // ==========================================================
  // Stimulus and observation signals
  logic                   mclk;
  logic                   sys_rst;
  logic                   other_rst;
  logic [1:0]             brownout_mode_cfg;
  logic                   brownout_level_select;
  logic                   sleep_state;
  logic                   supply_below;
  logic [`BRC_ADDR_W-1:0] avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [3:0]             avs_byteenable;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   detector_en_r;
  logic                   level_sel_r;
  logic                   brownout_reset_r;
  logic                   exec_enable_r;
  logic                   sw;
  logic [3:0]             a;
  logic [31:0]            d;
  logic [3:0]             be;
  int                     n_errors;
  int                     check_count;
  int                     cyc = 0;
  int                     n_bor = 0;
  int                     n;

  brc_brownout_reset_control i_brc_brownout_reset_control (
    .mclk(mclk), .sys_rst(sys_rst), .other_rst(other_rst),
    .brownout_mode_cfg(brownout_mode_cfg), .brownout_level_select(brownout_level_select),
    .sleep_state(sleep_state), .supply_below(supply_below), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .detector_en_r(detector_en_r),
    .level_sel_r(level_sel_r), .brownout_reset_r(brownout_reset_r),
    .exec_enable_r(exec_enable_r)
  );

  // ==========================================================
  // Clock, timeout and reset pulse monitor
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Whole run is well under this many cycles; a hang ends here
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (brownout_reset_r === 1'b1) n_bor++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  // ==========================================================
  // Expectation functions and helpers
  function automatic logic exp_det(input logic [1:0] m, input logic s, input logic sl);
    case (m)
      `BRC_MODE_ON:      exp_det = 1'b1;
      `BRC_MODE_NOSLEEP: exp_det = !sl;
      `BRC_MODE_SW:      exp_det = s;
      default:           exp_det = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] exp_reg(input logic s, input logic rdy);
    exp_reg = {24'h000000, s, 6'h00, rdy};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // One Avalon transfer; request held until waitrequest is sampled low, one wait state
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd,
                     input logic [3:0] ben, output logic [31:0] q);
    int w;
    w = 0;
    @(posedge mclk);
    avs_address    <= ad;
    avs_writedata  <= wd;
    avs_byteenable <= ben;
    avs_read       <= !wr;
    avs_write      <= wr;
    do begin
      @(posedge mclk);
      w++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    chk(32'(w), 32'h2);
  endtask

  task automatic wr(input logic [3:0] ad, input logic [31:0] wd, input logic [3:0] ben);
    logic [31:0] q;
    bus(1'b1, ad, wd, ben, q);
  endtask

  task automatic rd_chk(input logic [3:0] ad, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, ad, 32'h0, 4'hF, q);
    chk(q, exp);
  endtask

  // Bounded wait for the execution gate to open
  task automatic wait_exec(input int bound, output int k);
    k = 0;
    while (exec_enable_r !== 1'b1 && k < bound) begin
      @(posedge mclk);
      k++;
    end
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task final_report;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    n_errors = 0; check_count = 0;
    sys_rst = 1'b1; other_rst = 1'b0; brownout_mode_cfg = `BRC_MODE_OFF;
    brownout_level_select = 1'b0; sleep_state = 1'b0; supply_below = 1'b0;
    avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; avs_byteenable = 4'h0;
    void'($urandom(69177));
    tick(6);
    chk({avs_waitrequest, exec_enable_r, detector_en_r}, 32'h4);
    tick(6);
    sys_rst <= 1'b0;
    tick(3);
    chk(exec_enable_r, 32'h1);
    rd_chk(`BRC_CTRL_OFS, exp_reg(1'b1, 1'b0));
    wr(`BRC_CTRL_OFS, 32'hFFFFFFFF, 4'hF);
    rd_chk(`BRC_CTRL_OFS, exp_reg(1'b1, 1'b0));
    wr(`BRC_CTRL_OFS, 32'h0000007E, 4'hF);
    rd_chk(`BRC_CTRL_OFS, exp_reg(1'b0, 1'b0));
    chk(detector_en_r, 32'h0);
    wr(`BRC_CTRL_OFS, 32'h00000080, 4'hE);
    wr(4'h4, 32'h00000080, 4'hF);
    rd_chk(`BRC_CTRL_OFS, exp_reg(1'b0, 1'b0));
    rd_chk(4'h4, 32'h0);
    done("register basics");
    // Random writes in the off mode, mapped and unmapped words
    sw = 1'b0;
    for (int i = 0; i < 16; i++) begin
      a = 4'($urandom_range(0, 3)) << 2;
      d = $urandom;
      be = 4'($urandom);
      wr(a, d, be);
      if (a == `BRC_CTRL_OFS && be[0]) sw = d[7];
      rd_chk(a, (a == `BRC_CTRL_OFS) ? exp_reg(sw, 1'b0) : 32'h0);
      rd_chk(`BRC_CTRL_OFS, exp_reg(sw, 1'b0));
    end
    done("random access");
    brownout_level_select <= 1'b1;
    tick(2);
    chk(level_sel_r, 32'h1);
    brownout_level_select <= 1'b0;
    tick(2);
    chk(level_sel_r, 32'h0);
    done("level select");
    // Every mode against software enable and sleep
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        for (int sl = 0; sl < 2; sl++) begin
          wr(`BRC_CTRL_OFS, {24'h0, 1'(s), 7'h00}, 4'h1);
          brownout_mode_cfg <= 2'(m);
          sleep_state <= 1'(sl);
          tick(3);
          chk(detector_en_r, exp_det(2'(m), 1'(s), 1'(sl)));
          if (sl == 1) chk(exec_enable_r, 32'h0);
          // Dwell is far below the settle time, so only always-on reads ready
          rd_chk(`BRC_CTRL_OFS, exp_reg(1'(s), 1'(m == 3)));
        end
      end
    end
    sleep_state <= 1'b0;
    done("mode table");
    // Software mode: ready only after the detector settles
    brownout_mode_cfg <= `BRC_MODE_SW;
    wr(`BRC_CTRL_OFS, 32'h0, 4'h1);
    tick(3);
    wr(`BRC_CTRL_OFS, 32'h80, 4'h1);
    rd_chk(`BRC_CTRL_OFS, exp_reg(1'b1, 1'b0));
    tick(`BRC_SETTLE_CYC + 10);
    rd_chk(`BRC_CTRL_OFS, exp_reg(1'b1, 1'b1));
    done("software settle");
    // Off in sleep: wake waits for the detector to settle again
    brownout_mode_cfg <= `BRC_MODE_NOSLEEP;
    wait_exec(60, n);
    chk(exec_enable_r, 32'h1);
    sleep_state <= 1'b1;
    tick(3);
    chk({detector_en_r, exec_enable_r}, 32'h0);
    sleep_state <= 1'b0;
    wait_exec(100, n);
    chk(n >= `BRC_SETTLE_CYC - 5 && n <= `BRC_SETTLE_CYC + 20, 32'h1);
    done("wake off in sleep");
    // Always on: detector stays on asleep, wake has no delay
    brownout_mode_cfg <= `BRC_MODE_ON;
    tick(5);
    sleep_state <= 1'b1;
    tick(3);
    chk(detector_en_r, 32'h1);
    sleep_state <= 1'b0;
    wait_exec(10, n);
    chk(n <= 3, 32'h1);
    done("wake always on");
    // Glitch filter boundary, then a real brown-out restores the enable
    wr(`BRC_CTRL_OFS, 32'h0, 4'h1);
    n = n_bor;
    supply_below <= 1'b1;
    tick(`BRC_GLITCH_CYC);
    supply_below <= 1'b0;
    tick(3);
    chk(32'(n_bor - n), 32'h0);
    supply_below <= 1'b1;
    tick(`BRC_GLITCH_CYC + 1);
    supply_below <= 1'b0;
    tick(3);
    chk(32'(n_bor != n), 32'h1);
    supply_below <= 1'b1;
    tick(`BRC_GLITCH_CYC + 5);
    chk({brownout_reset_r, exec_enable_r}, 32'h2);
    supply_below <= 1'b0;
    wait_exec(60, n);
    rd_chk(`BRC_CTRL_OFS, exp_reg(1'b1, 1'b1));
    done("glitch filter");
    // Other reset holds execution while supply is low, keeps the enable
    brownout_mode_cfg <= `BRC_MODE_NOSLEEP;
    wr(`BRC_CTRL_OFS, 32'h0, 4'h1);
    tick(`BRC_SETTLE_CYC + 10);
    supply_below <= 1'b1;
    other_rst <= 1'b1;
    tick(1);
    other_rst <= 1'b0;
    tick(8);
    chk(exec_enable_r, 32'h0);
    supply_below <= 1'b0;
    wait_exec(5, n);
    chk(exec_enable_r, 32'h1);
    rd_chk(`BRC_CTRL_OFS, exp_reg(1'b0, 1'b1));
    done("execution gate");
    final_report();
  end
endmodule
